// ### pkg/aout_regs.svh
/*
  Register offsets, field positions, signal and status codes and timing counts for the analog output channel control block.
  Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
`ifndef AOUT_REGS_SVH
`define AOUT_REGS_SVH

// ********************************************************************
// Register byte offsets
// ********************************************************************
`define REG_CTRL        8'h00
`define REG_SIGTYPE     8'h04
`define REG_DATATYPE    8'h08
`define REG_MIN         8'h0c
`define REG_MAX         8'h10
`define REG_DATA        8'h14
`define REG_STATUS      8'h18
`define REG_CODE        8'h1c

// ********************************************************************
// Control fields
// ********************************************************************
`define CTRL_RUN        0
`define CTRL_LADDER     1
`define CTRL_SCAN_END   2
`define CTRL_REFRESH    3
`define CTRL_STOP_WRITE 4
`define CTRL_INIT_DONE  5
`define CTRL_SUPPLY_OK  6

// ********************************************************************
// Codes and spans
// ********************************************************************
`define SIG_VOLTAGE     8'h00
`define SIG_CURRENT     8'h01
`define SIG_UNUSED      8'hff
`define DTYPE_BINARY    8'h00
`define DTYPE_OPTIONAL  8'h01
`define BIN_FULL_SCALE  16'h0fff
`define DAC_FULL        12'hfff
`define CURRENT_ZERO    12'h333
`define CURRENT_SPAN    12'hccc

`define ST_NORMAL       16'h0000
`define ST_INIT         16'h0002
`define ST_BADPARAM     16'h0003
`define ST_HWFAIL       16'h0004
`define BIT_INIT        0
`define BIT_PARAM       1
`define BIT_SUPPLY      2
`define BIT_RANGE       3

// ********************************************************************
// Timing
// ********************************************************************
`define CLK_MHZ         100
`define REFRESH_MS      10
`define REFRESH_CYCLES  (`REFRESH_MS * 1000 * `CLK_MHZ)

`endif

// ### pkg/aout_pkg.sv
/*
  Types for the analog output channel control block.
  Assumes aout_regs.svh for the numeric constants.
*/
package aout_pkg;
  typedef logic [31:0] word_t;
  typedef logic [11:0] dac_t;
  typedef enum logic [1:0] {
    seq_idle,
    seq_init,
    seq_live
  } seq_e;
endpackage

// ### logic/aout_scale.sv
/*
  Maps one channel data word onto the 12-bit converter code for voltage or current output.
  Assumes all inputs are registered on the same clock; the result is combinational.
*/
`timescale 1ns/10ps
`include "aout_regs.svh"

module aout_scale
  import aout_pkg::*;
(
  input  wire logic [7:0]  sig_type,
  input  wire logic [7:0]  data_type,
  input  wire logic [15:0] min_val,
  input  wire logic [15:0] max_val,
  input  wire logic [15:0] data,
  output logic             out_of_range,
  output logic             bad_param,
  output aout_pkg::dac_t   code
);
  logic signed [17:0] lo;
  logic signed [17:0] hi;
  logic signed [17:0] v;
  logic signed [17:0] off;
  logic        [17:0] span;
  logic        [29:0] frac;
  logic        [11:0] unit;
  logic        [23:0] cur;

  always_comb begin
    bad_param = 1'b0;
    if (data_type == `DTYPE_OPTIONAL) begin  // [R3] [R4]
      lo = 18'(signed'(min_val));
      hi = 18'(signed'(max_val));
      v  = 18'(signed'(data));
      if (hi <= lo)
        bad_param = 1'b1;
    end else begin
      lo = 18'sd0;
      hi = 18'(`BIN_FULL_SCALE);
      v  = {2'b00, data};
      if (data_type != `DTYPE_BINARY)
        bad_param = 1'b1;
    end
    if (sig_type != `SIG_VOLTAGE && sig_type != `SIG_CURRENT && sig_type != `SIG_UNUSED)
      bad_param = 1'b1;  // [R1]
    out_of_range = (v < lo) || (v > hi);
    off  = (v < lo) ? 18'sd0 : ((v > hi) ? hi - lo : v - lo);
    span = bad_param ? 18'd1 : 18'(hi - lo);
    frac = 30'(30'(off) * 30'(`DAC_FULL)) / 30'(span);
    unit = frac[11:0];
    cur  = 24'(unit) * 24'(`CURRENT_SPAN) / 24'(`DAC_FULL);
    if (sig_type == `SIG_CURRENT)
      code = `CURRENT_ZERO + cur[11:0];  // [R5]
    else if (sig_type == `SIG_VOLTAGE)
      code = unit;  // [R5]
    else
      code = 12'h000;
  end
endmodule // aout_scale

// ### logic/aout_ctrl.sv
/*
  Analog output channel control: configuration registers, refresh scheduling for the scan-end and
  instruction-driven schemes, per-channel status and converter codes.
  Assumes an AXI4-Lite master on mclk and a converter that takes a 12-bit code per channel.
*/
`timescale 1ns/10ps
`include "aout_regs.svh"

// Operation
// [R1] Signal type code 0 is voltage, 1 current, 255 unused.
// [R2] Software sets unused channels to the default type or the unused code.
// [R3] Data type 0 is binary full scale, 1 is optional range.
// [R4] Optional range maps data between signed minimum and maximum onto span.
// [R5] Scan-end scheme converts data to 0-10 V or 4-20 mA per type.
// [R6] Scan-end running refresh at scan end or 10 ms, whichever later.
// [R7] Scan-end stopped output holds at zero or configured minimum.
// [R8] Instruction scheme running refreshes only on the refresh instruction.
// [R9] Instruction scheme stopped: no refresh, but stopped write still applies.
// [R10] Status word per channel; zero means normal operation.
// [R11] Scan-end status updates running or stopped, at scan end or 10 ms.
// [R12] Scan-end codes: 0 normal, 2 init, 3 bad parameter, 4 supply failure.
// [R13] Instruction status bits: 0 init, 1 parameter, 2 supply error.
// [R14] Instruction status bit 3 marks out-of-range data; bits 4-15 zero.
module aout_ctrl
  import aout_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire aout_pkg::word_t      s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output aout_pkg::word_t           s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 scan_end,
  input  wire logic                 supply_ok,
  output aout_pkg::dac_t            dac_code,
  output logic                      dac_current
);
  import aout_pkg::*;

  // ********************************************************************
  // Register state
  // ********************************************************************
  logic [6:0]  ctrl;
  logic [7:0]  sig_type;
  logic [7:0]  data_type;
  logic [15:0] min_val;
  logic [15:0] max_val;
  logic [15:0] data;
  logic [15:0] live_data;
  logic [15:0] status;
  seq_e        seq;
  logic [31:0] tick_cnt;
  logic        tick_seen;
  logic        scan_seen;
  logic        refresh_pulse;
  logic        stop_write_pulse;
  logic        cfg_write;
  logic        supply_q1;
  logic        supply_q2;
  logic        scan_q1;
  logic        scan_q2;
  logic        scan_q3;
  logic        scan_rise;
  logic        update_evt;
  logic        scan_evt;
  logic        out_of_range;
  logic        bad_param;
  dac_t        code;
  logic [15:0] next_status;

  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  word_t       w_data;
  logic [3:0]  w_strb;
  logic        do_write;

  wire run     = ctrl[`CTRL_RUN];
  wire ladder  = ctrl[`CTRL_LADDER];

  function automatic logic [15:0] merge16(input logic [15:0] old, input word_t val, input logic [3:0] be);
    merge16 = {be[1] ? val[15:8] : old[15:8], be[0] ? val[7:0] : old[7:0]};
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= `REG_CODE);
  endfunction

  // ********************************************************************
  // Pin synchronisers
  // ********************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      supply_q1 <= 1'b0;
      supply_q2 <= 1'b0;
      scan_q1   <= 1'b0;
      scan_q2   <= 1'b0;
      scan_q3   <= 1'b0;
    end else begin
      supply_q1 <= supply_ok;
      supply_q2 <= supply_q1;
      scan_q1   <= scan_end;
      scan_q2   <= scan_q1;
      scan_q3   <= scan_q2;
    end
  end
  assign scan_rise = scan_q2 & ~scan_q3;

  // ********************************************************************
  // AXI4-Lite write channel
  // ********************************************************************
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_bresp   = mapped(aw_addr) ? 2'b00 : 2'b10;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // Configuration registers
  // ********************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl             <= 7'h00;
      sig_type         <= `SIG_VOLTAGE;
      data_type        <= `DTYPE_BINARY;
      min_val          <= 16'h0000;
      max_val          <= 16'h0000;
      data             <= 16'h0000;
      refresh_pulse    <= 1'b0;
      stop_write_pulse <= 1'b0;
      cfg_write        <= 1'b0;
    end else begin
      refresh_pulse    <= 1'b0;
      stop_write_pulse <= 1'b0;
      cfg_write        <= 1'b0;
      if (do_write) begin
        case (aw_addr)
          `REG_CTRL: begin
            if (w_strb[0]) begin
              ctrl[2:0]              <= w_data[2:0];
              ctrl[`CTRL_INIT_DONE]  <= w_data[`CTRL_INIT_DONE];
              refresh_pulse          <= w_data[`CTRL_REFRESH];
              stop_write_pulse       <= w_data[`CTRL_STOP_WRITE];
              cfg_write              <= w_data[`CTRL_LADDER] != ctrl[`CTRL_LADDER];
            end
          end
          `REG_SIGTYPE: begin
            if (w_strb[0]) begin
              sig_type  <= w_data[7:0];  // [R1] [R2]
              cfg_write <= 1'b1;
            end
          end
          `REG_DATATYPE: begin
            if (w_strb[0]) begin
              data_type <= w_data[7:0];  // [R3]
              cfg_write <= 1'b1;
            end
          end
          `REG_MIN: begin
            min_val   <= merge16(min_val, w_data, w_strb);  // [R4]
            cfg_write <= 1'b1;
          end
          `REG_MAX: begin
            max_val   <= merge16(max_val, w_data, w_strb);  // [R4]
            cfg_write <= 1'b1;
          end
          `REG_DATA: data <= merge16(data, w_data, w_strb);
          default: ;
        endcase
      end
    end
  end

  // ********************************************************************
  // Refresh scheduling
  // ********************************************************************
  // A refresh needs both a scan end and a full 10 ms period, so the later one wins.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tick_cnt  <= 32'h0000_0000;
      tick_seen <= 1'b0;
      scan_seen <= 1'b0;
    end else if (update_evt) begin
      tick_cnt  <= 32'h0000_0000;
      tick_seen <= 1'b0;
      scan_seen <= scan_evt;
    end else begin
      if (tick_cnt >= 32'(`REFRESH_CYCLES - 1))
        tick_seen <= 1'b1;
      else
        tick_cnt <= tick_cnt + 32'h0000_0001;
      if (scan_evt)
        scan_seen <= 1'b1;
    end
  end
  // A scan end that lands on the update cycle counts towards the next period, so none is lost.
  assign scan_evt = scan_rise || (ctrl[`CTRL_SCAN_END] && do_write && aw_addr == `REG_CTRL);
  // Stopped controllers execute no scans, so the 10 ms period alone paces status.
  assign update_evt = tick_seen && (scan_seen || !run);  // [R6] [R11]

  // ********************************************************************
  // Output data
  // ********************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      live_data <= 16'h0000;
    end else if (!ladder) begin
      if (!run)
        live_data <= (data_type == `DTYPE_OPTIONAL) ? min_val : 16'h0000;  // [R7]
      else if (update_evt)
        live_data <= data;  // [R6]
    end else begin
      if (run && refresh_pulse)
        live_data <= data;  // [R8]
      else if (!run && stop_write_pulse)
        live_data <= data;  // [R9]
    end
  end

  aout_scale u_scale (
    .sig_type     (sig_type),
    .data_type    (data_type),
    .min_val      (min_val),
    .max_val      (max_val),
    .data         (live_data),
    .out_of_range (out_of_range),
    .bad_param    (bad_param),
    .code         (code)
  );

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dac_code    <= 12'h000;
      dac_current <= 1'b0;
    end else begin
      dac_code    <= code;  // [R5]
      dac_current <= sig_type == `SIG_CURRENT;
    end
  end

  // ********************************************************************
  // Status
  // ********************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n)
      seq <= seq_idle;
    else
      case (seq)
        seq_idle: seq <= seq_init;
        seq_init: if (ctrl[`CTRL_INIT_DONE]) seq <= seq_live;
        seq_live: if (cfg_write && ladder) seq <= seq_init;
        default:  seq <= seq_idle;
      endcase
  end

  always_comb begin
    next_status = 16'h0000;
    if (ladder) begin
      next_status[`BIT_INIT]   = seq != seq_live;  // [R13]
      next_status[`BIT_PARAM]  = bad_param;  // [R13]
      next_status[`BIT_SUPPLY] = !supply_q2;  // [R13]
      next_status[`BIT_RANGE]  = out_of_range;  // [R14]
    end else if (seq != seq_live)
      next_status = `ST_INIT;  // [R12]
    else if (bad_param)
      next_status = `ST_BADPARAM;  // [R12]
    else if (!supply_q2)
      next_status = `ST_HWFAIL;  // [R12]
    else
      next_status = `ST_NORMAL;  // [R10]
  end

  always_ff @(posedge mclk) begin
    if (!rst_n)
      status <= `ST_INIT;
    else if (ladder || update_evt)
      status <= next_status;  // [R11]
  end

  // ********************************************************************
  // AXI4-Lite read channel
  // ********************************************************************
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
      case (s_axi_araddr)
        `REG_CTRL:     s_axi_rdata <= {25'h0, supply_q2, ctrl[`CTRL_INIT_DONE], 2'b00, ctrl[2:0]};
        `REG_SIGTYPE:  s_axi_rdata <= {24'h0, sig_type};
        `REG_DATATYPE: s_axi_rdata <= {24'h0, data_type};
        `REG_MIN:      s_axi_rdata <= {16'h0, min_val};
        `REG_MAX:      s_axi_rdata <= {16'h0, max_val};
        `REG_DATA:     s_axi_rdata <= {16'h0, data};
        `REG_STATUS:   s_axi_rdata <= {16'h0, status};
        `REG_CODE:     s_axi_rdata <= {20'h0, dac_code};
        default:       s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // aout_ctrl

// ### verification/aout_load.sv
/*
  Analog load model that turns the converter code into a level.
  Assumes a 12-bit code with 0..fff spanning 0-10 V or 0-20 mA.
*/
`timescale 1ns/10ps
module aout_load
  import aout_pkg::*;
(
  input  wire aout_pkg::dac_t dac_code,
  input  wire logic           dac_current,
  output logic [15:0]         level
);
  // The level is in millivolts for voltage and microamps for current.
  always_comb begin
    if (dac_current) begin
      level = 16'((32'(dac_code) * 20000) / 4095);
    end else begin
      level = 16'((32'(dac_code) * 10000) / 4095);
    end
  end
endmodule // aout_load

// ### verification/aout_ctrl_props.sv
/*
  Checker for the control block ports.
  Assumes it is bound into aout_ctrl on the mclk domain.
*/
`timescale 1ns/10ps
module aout_ctrl_props
  import aout_pkg::*;
(
  input wire logic            mclk,
  input wire logic            rst_n,
  input wire logic            s_axi_awvalid,
  input wire logic            s_axi_awready,
  input wire logic            s_axi_wvalid,
  input wire logic            s_axi_wready,
  input wire logic [1:0]      s_axi_bresp,
  input wire logic            s_axi_bvalid,
  input wire logic            s_axi_bready,
  input wire logic            s_axi_arvalid,
  input wire logic            s_axi_arready,
  input wire aout_pkg::word_t s_axi_rdata,
  input wire logic [1:0]      s_axi_rresp,
  input wire logic            s_axi_rvalid,
  input wire logic            s_axi_rready,
  input wire aout_pkg::dac_t  dac_code,
  input wire logic            dac_current
);
  // ****************************************
  // Bus and output relations
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_reset_clears: assert property ($rose(rst_n) |-> !s_axi_bvalid && !s_axi_rvalid && dac_code == 12'h000)
    else $error("outputs not cleared by reset");
  a_write_answer: assert property (disable iff (!rst_n) wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_busy_refuse: assert property (disable iff (!rst_n) $rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_bresp_drop: assert property (disable iff (!rst_n) s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired");
  a_read_answer: assert property (disable iff (!rst_n) rd_taken |=> s_axi_rvalid)
    else $error("read data late");
  a_rresp_drop: assert property (disable iff (!rst_n) s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not retired");
  a_read_refuse: assert property (disable iff (!rst_n) s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  a_slverr_zero: assert property (disable iff (!rst_n) s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  a_bresp_legal: assert property (disable iff (!rst_n) s_axi_bvalid |-> s_axi_bresp inside {2'b00, 2'b10})
    else $error("illegal write response");
  a_current_span: assert property (disable iff (!rst_n)
    dac_current && $stable(dac_code) && $stable(dac_current) |-> dac_code >= 12'h333)
    else $error("current code below 4 mA");
endmodule // aout_ctrl_props

bind aout_ctrl aout_ctrl_props u_props (.mclk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dac_code, .dac_current);

// ### verification/analog_output_channel_control_test.sv
/*
  Testbench for the analog output channel control block.
  Assumes the register map of aout_regs.svh and an AXI4-Lite master.
*/
`timescale 1ns/10ps
`include "aout_regs.svh"
module analog_output_channel_control_test;
  import aout_pkg::*;
  logic        mclk, rst_n, scan_end, supply_ok, dac_current;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, wresp, rs;
  word_t       s_axi_wdata, s_axi_rdata, rd;
  dac_t        dac_code;
  logic [15:0] level;
  int          err_count, n_tests;

  aout_ctrl dut (.mclk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .scan_end, .supply_ok,
    .dac_code, .dac_current);
  aout_load u_load (.dac_code, .dac_current, .level);

  always #5 mclk = ~mclk;

  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic check_word(input word_t got, input word_t exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_level(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: level %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input word_t d);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge mclk);
      if (!aw_done && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (!s_axi_bvalid);
    wresp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd_reg(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input word_t exp);
    rd_reg(a);
    check_word(rd, exp);
  endtask
  // The output register lags the live data by one cycle, so four is ample.
  task automatic kick(input word_t c);
    wr(`REG_CTRL, c);
    repeat (4) @(posedge mclk);
  endtask
  task automatic conclude;
    if (err_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    conclude();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    scan_end = 1'b0;
    supply_ok = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    err_count = 0;
    n_tests = 0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    rd_chk(`REG_STATUS, 32'h2);
    wr(`REG_DATA, 32'h800);
    wr(`REG_CTRL, 32'h20);
    repeat (3) begin
      scan_end <= 1'b1;
      repeat (4) @(posedge mclk);
      scan_end <= 1'b0;
      repeat (4) @(posedge mclk);
    end
    rd_chk(`REG_CODE, 32'h0);
    check_level(level, 16'd0);
    kick(32'h21);
    scan_end <= 1'b1;
    repeat (4) @(posedge mclk);
    scan_end <= 1'b0;
    repeat (4) @(posedge mclk);
    rd_chk(`REG_CODE, 32'h0);
    rd_chk(`REG_STATUS, 32'h2);
    kick(32'h23);
    rd_chk(`REG_STATUS, 32'h0);
    kick(32'h2b);
    rd_chk(`REG_CODE, 32'h800);
    check_level(level, 16'd5001);
    rd_chk(`REG_CTRL, 32'h63);
    wr(`REG_DATA, 32'h100);
    repeat (4) @(posedge mclk);
    rd_chk(`REG_CODE, 32'h800);
    kick(32'h2b);
    rd_chk(`REG_CODE, 32'h100);
    kick(32'h22);
    wr(`REG_DATA, 32'h200);
    kick(32'h2a);
    rd_chk(`REG_CODE, 32'h100);
    kick(32'h32);
    rd_chk(`REG_CODE, 32'h200);
    kick(32'h23);
    wr(`REG_SIGTYPE, 32'h1);
    wr(`REG_DATA, 32'h0);
    kick(32'h2b);
    rd_chk(`REG_CODE, 32'h333);
    check_level(level, 16'd4000);
    check_word({31'h0, dac_current}, 32'h1);
    wr(`REG_DATA, 32'hfff);
    kick(32'h2b);
    check_level(level, 16'd20000);
    wr(`REG_SIGTYPE, 32'hff);
    kick(32'h2b);
    rd_chk(`REG_CODE, 32'h0);
    rd_chk(`REG_STATUS, 32'h0);
    wr(`REG_SIGTYPE, 32'h7);
    repeat (2) @(posedge mclk);
    rd_chk(`REG_STATUS, 32'h2);
    wr(`REG_SIGTYPE, 32'h0);
    wr(`REG_DATA, 32'h1000);
    kick(32'h2b);
    rd_chk(`REG_STATUS, 32'h8);
    rd_chk(`REG_CODE, 32'hfff);
    wr(`REG_DATA, 32'h800);
    supply_ok <= 1'b0;
    kick(32'h2b);
    rd_chk(`REG_STATUS, 32'h4);
    rd_chk(`REG_CTRL, 32'h23);
    supply_ok <= 1'b1;
    wr(`REG_DATATYPE, 32'h1);
    wr(`REG_MIN, 32'hfc18);
    wr(`REG_MAX, 32'h3e8);
    wr(`REG_DATA, 32'h3e8);
    kick(32'h2b);
    rd_chk(`REG_CODE, 32'hfff);
    wr(`REG_DATA, 32'hfc18);
    kick(32'h2b);
    rd_chk(`REG_CODE, 32'h0);
    rd_chk(`REG_MIN, 32'hfc18);
    rd_chk(`REG_STATUS, 32'h0);
    wr(`REG_MAX, 32'hfc18);
    repeat (2) @(posedge mclk);
    rd_chk(`REG_STATUS, 32'h2);
    wr(8'h20, 32'h1);
    check_word({30'h0, wresp}, 32'h2);
    rd_chk(8'h20, 32'h0);
    check_word({30'h0, rs}, 32'h2);
    conclude();
  end
endmodule // analog_output_channel_control_test
